// [rtl/ufedc_top.sv]
// Endpoint buffer, DMA request, setup buffer and power-state control of a USB function.
// What this block does
// - DMA drain of receive side switches side
// - Full 64-byte DMA fill enables packet automatically
// - Bulk-in DMA request stays while space exists
// - VBUS low freezes the powered state
// - Attached cable with SE0 means bus reset
// - Routing bit sends suspend and resume lines
// - Set-configuration flag is set; configuration-valid flag is set only for a nonzero configuration value
// - Setup reception beats CPU setup reads
// - Bulk-out clear ignored while DMA enabled
// - IN to empty buffer: NAK, then request flag
// - Zero-length bulk-out packets dropped under DMA
// - Bulk-out DMA request follows buffer data presence, bulk-in request follows free space
// - DMA data accesses are byte wide
`timescale 1ns/100ps
module ufedc_top #(
  parameter int unsigned DEPTH = ufedc_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ufedc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vbus_pin,
  input wire logic dp_pin,
  input wire logic dm_pin,
  input wire logic rx_wr,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  output logic rx_ready,
  input wire logic tx_rd,
  input wire logic tx_ack,
  output logic [7:0] tx_data,
  output logic [$clog2(DEPTH+1)-1:0] tx_len,
  output logic tx_ready,
  input wire logic in_token,
  output logic in_nak,
  input wire logic setup_start,
  input wire logic setup_wr,
  input wire logic [7:0] setup_data,
  input wire logic suspend_evt,
  input wire logic resume_evt,
  input wire logic set_config_evt,
  input wire logic [7:0] config_value,
  output logic dma_req_out,
  output logic dma_req_in,
  output logic usb_powered,
  output logic bus_reset,
  output logic suspend_irq_line,
  output logic wake_irq_line
);
  import ufedc_pkg::*;

  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);

  logic [2:0] meta_reg, sync_reg;
  logic vbus_s, dp_s, dm_s, se0;
  logic [1:0] dma_reg, dma_next;
  logic route_reg, route_next;
  logic tr_reg, tr_next, nak_reg, nak_next;
  logic susp_reg, susp_next, resume_reg, resume_next;
  logic set_config_flag_reg, set_config_flag_next, config_valid_flag_reg, config_valid_flag_next;
  logic busrst_reg, busrst_next, powered_reg, powered_next;
  logic sline_reg, sline_next, wline_reg, wline_next;
  logic [31:0] prdata_reg, prdata_next, rd_mux;
  logic [7:0] setup_mem_reg [SETUP_LEN];
  logic [7:0] setup_mem_next [SETUP_LEN];
  logic [2:0] swidx_reg, swidx_next, sridx_reg, sridx_next;
  logic setup_busy, setup_busy_next;
  logic acc, wr_acc, rd_acc, mapped;
  logic [3:0] trig;
  logic [31:0] clr2;
  logic dma_bo, dma_bi;
  logic bo_rd_en, bo_rd_done, bo_clear, bo_commit;
  logic bi_wr, bi_commit, bi_clear;
  logic [7:0] bo_rd_data;
  logic [CW-1:0] bo_rd_len, bo_wr_cnt, bi_rd_len, bi_wr_cnt;
  logic bo_rd_avail, bo_rd_last, bo_wr_free, bo_rd_side, bo_wr_side;
  logic bi_rd_avail, bi_wr_free, bi_rd_side, bi_wr_side;

  // Pins are asynchronous to clk; only the second stage is used.
  assign vbus_s = sync_reg[0];
  assign dp_s = sync_reg[1];
  assign dm_s = sync_reg[2];
  assign se0 = vbus_s && !dp_s && !dm_s;

  // Zero-wait slave: read data is captured in the setup cycle.
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign mapped = paddr inside {OFF_TRIGGER, OFF_DMA, OFF_CTRL, OFF_WAKE_IRQ_LINE, OFF_IRQ2,
                                OFF_SETUP, OFF_BO_DATA, OFF_BI_DATA, OFF_BO_SIZE, OFF_STATUS};
  assign pslverr = acc && !mapped;
  assign trig = (wr_acc && paddr == OFF_TRIGGER) ? pwdata[3:0] : 4'h0;
  assign clr2 = (wr_acc && paddr == OFF_IRQ2) ? pwdata : 32'h0;
  assign dma_bo = dma_reg[DMA_BO_EN];
  assign dma_bi = dma_reg[DMA_BI_EN];

  // Data registers take only byte lane 0, so DMA moves one byte per access.
  assign bo_rd_en = rd_acc && paddr == OFF_BO_DATA;
  assign bo_rd_done = trig[TRG_RD_DONE] || (dma_bo && bo_rd_en && bo_rd_last);
  assign bo_clear = trig[TRG_CLR_BO] && !dma_bo;
  assign bo_commit = rx_end && !(dma_bo && bo_wr_cnt == '0);
  assign bi_wr = wr_acc && paddr == OFF_BI_DATA;
  assign bi_commit = trig[TRG_PKT_EN] || (dma_bi && bi_wr && bi_wr_free && bi_wr_cnt == LAST);
  assign bi_clear = trig[TRG_CLR_BI];

  assign dma_req_out = dma_bo && bo_rd_avail && bo_rd_len != '0;
  assign dma_req_in = dma_bi && bi_wr_free;
  assign rx_ready = bo_wr_free;
  assign tx_ready = bi_rd_avail;
  assign tx_len = bi_rd_len;
  assign in_nak = nak_reg;
  assign usb_powered = powered_reg;
  assign bus_reset = busrst_reg;
  assign suspend_irq_line = sline_reg;
  assign wake_irq_line = wline_reg;

  ufedc_dbuf #(.DW(8), .DEPTH(DEPTH)) u_bulk_out (
    .clk(clk),
    .rst_b(rst_b),
    .clear(bo_clear),
    .wr_en(rx_wr),
    .wr_data(rx_data),
    .wr_commit(bo_commit),
    .rd_en(bo_rd_en),
    .rd_done(bo_rd_done),
    .rd_data(bo_rd_data),
    .rd_len(bo_rd_len),
    .wr_cnt(bo_wr_cnt),
    .rd_avail(bo_rd_avail),
    .rd_last(bo_rd_last),
    .wr_free(bo_wr_free),
    .rd_side(bo_rd_side),
    .wr_side(bo_wr_side)
  );

  ufedc_dbuf #(.DW(8), .DEPTH(DEPTH)) u_bulk_in (
    .clk(clk),
    .rst_b(rst_b),
    .clear(bi_clear),
    .wr_en(bi_wr),
    .wr_data(pwdata[7:0]),
    .wr_commit(bi_commit),
    .rd_en(tx_rd),
    .rd_done(tx_ack),
    .rd_data(tx_data),
    .rd_len(bi_rd_len),
    .wr_cnt(bi_wr_cnt),
    .rd_avail(bi_rd_avail),
    .rd_last(),
    .wr_free(bi_wr_free),
    .rd_side(bi_rd_side),
    .wr_side(bi_wr_side)
  );

  always_comb begin
    unique case (paddr)
      OFF_DMA: rd_mux = {30'h0, dma_reg};
      OFF_CTRL: rd_mux = {31'h0, route_reg};
      OFF_WAKE_IRQ_LINE: rd_mux = {31'h0, tr_reg};
      OFF_IRQ2: rd_mux = {26'h0, powered_reg, busrst_reg, config_valid_flag_reg, set_config_flag_reg, resume_reg, susp_reg};
      // While a setup packet lands the CPU sees zero instead of half-written bytes.
      OFF_SETUP: rd_mux = setup_busy ? 32'h0 : {24'h0, setup_mem_reg[sridx_reg]};
      OFF_BO_DATA: rd_mux = {24'h0, bo_rd_data};
      OFF_BO_SIZE: rd_mux = {{(32 - CW){1'b0}}, bo_rd_len};
      OFF_STATUS: rd_mux = {29'h0, setup_busy, bi_wr_free, bo_rd_avail};
      default: rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    prdata_next = (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
    dma_next = (wr_acc && paddr == OFF_DMA) ? pwdata[1:0] : dma_reg;
    route_next = (wr_acc && paddr == OFF_CTRL) ? pwdata[CTRL_SUSP_ROUTE] : route_reg;
    // Hardware set wins over a write-one clear in the same cycle.
    tr_next = nak_reg || (tr_reg && !(wr_acc && paddr == OFF_WAKE_IRQ_LINE && pwdata[WAKE_IRQ_LINE_TR]));
    nak_next = in_token && !bi_rd_avail;
    susp_next = suspend_evt || (susp_reg && !clr2[IRQ2_SUSP]);
    resume_next = resume_evt || (resume_reg && !clr2[IRQ2_RESUME]);
    set_config_flag_next = set_config_evt || (set_config_flag_reg && !clr2[IRQ2_SET_CONFIG_FLAG]);
    busrst_next = se0 || (busrst_reg && !clr2[IRQ2_BUSRST]);
    config_valid_flag_next = config_valid_flag_reg;
    if (se0) begin
      config_valid_flag_next = 1'b0;
    end
    if (set_config_evt) begin
      config_valid_flag_next = config_value != 8'h00;
    end
    // Bus levels mean nothing without VBUS, so the state is held.
    powered_next = vbus_s ? 1'b1 : powered_reg;
    sline_next = route_reg && susp_reg;
    wline_next = route_reg && resume_reg;
  end

  always_comb begin
    setup_mem_next = setup_mem_reg;
    swidx_next = swidx_reg;
    sridx_next = sridx_reg;
    setup_busy_next = setup_busy;
    if (setup_start) begin
      setup_busy_next = 1'b1;
      swidx_next = 3'h0;
      sridx_next = 3'h0;
    end else begin
      if (setup_wr && setup_busy) begin
        setup_mem_next[swidx_reg] = setup_data;
        swidx_next = swidx_reg + 3'h1;
        setup_busy_next = swidx_reg != SETUP_LAST;
      end
      if (rd_acc && paddr == OFF_SETUP && !setup_busy) begin
        sridx_next = sridx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prdata_reg <= PRDATA_RST;
      dma_reg <= DMA_RST;
      route_reg <= CTRL_RST;
      tr_reg <= 1'b0;
      nak_reg <= 1'b0;
      susp_reg <= 1'b0;
      resume_reg <= 1'b0;
      set_config_flag_reg <= 1'b0;
      config_valid_flag_reg <= 1'b0;
      busrst_reg <= 1'b0;
      powered_reg <= 1'b0;
      sline_reg <= 1'b0;
      wline_reg <= 1'b0;
      setup_mem_reg <= '{default: '0};
      swidx_reg <= 3'h0;
      sridx_reg <= 3'h0;
      setup_busy <= 1'b0;
    end else begin
      meta_reg <= {dm_pin, dp_pin, vbus_pin};
      sync_reg <= meta_reg;
      prdata_reg <= prdata_next;
      dma_reg <= dma_next;
      route_reg <= route_next;
      tr_reg <= tr_next;
      nak_reg <= nak_next;
      susp_reg <= susp_next;
      resume_reg <= resume_next;
      set_config_flag_reg <= set_config_flag_next;
      config_valid_flag_reg <= config_valid_flag_next;
      busrst_reg <= busrst_next;
      powered_reg <= powered_next;
      sline_reg <= sline_next;
      wline_reg <= wline_next;
      setup_mem_reg <= setup_mem_next;
      swidx_reg <= swidx_next;
      sridx_reg <= sridx_next;
      setup_busy <= setup_busy_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  bo_autodone_a: assert property (
    dma_bo && bo_rd_en && bo_rd_last |=> bo_rd_side != $past(bo_rd_side))
    else $error("bulk-out side kept after DMA drain");
  bi_autopkt_a: assert property (
    dma_bi && bi_wr && bi_wr_free && bi_wr_cnt == LAST |=> bi_wr_cnt == '0 && bi_wr_side != $past(bi_wr_side))
    else $error("bulk-in side not enabled after full fill");
  bi_short_a: assert property (
    bi_wr && bi_wr_cnt != LAST && !trig[TRG_PKT_EN] && !bi_clear |=> $stable(bi_wr_side))
    else $error("bulk-in side switched on short fill");
  dreq_in_a: assert property (
    dma_bi && !bi_rd_avail |-> dma_req_in)
    else $error("bulk-in DMA request missing with free space");
  vbus_hold_a: assert property (
    !vbus_s |=> $stable(usb_powered))
    else $error("powered state changed with VBUS low");
  se0_reset_a: assert property (
    se0 |=> bus_reset)
    else $error("bus reset not flagged on SE0");
  susp_route_a: assert property (
    route_reg && susp_reg && resume_reg |=> suspend_irq_line && wake_irq_line)
    else $error("suspend or wake line not driven");
  set_config_a: assert property (
    set_config_evt && config_value != 8'h00 |=> set_config_flag_reg && config_valid_flag_reg)
    else $error("configuration flags not set");
  setup_prio_a: assert property (
    psel && !penable && !pwrite && paddr == OFF_SETUP && setup_busy |=> prdata == 32'h0)
    else $error("setup read not abandoned");
  bo_clear_a: assert property (
    dma_bo && trig[TRG_CLR_BO] && !rx_end && !bo_rd_done |=> $stable(bo_rd_len))
    else $error("bulk-out cleared under DMA");
  zlp_drop_a: assert property (
    dma_bo && rx_end && bo_wr_cnt == '0 |=> $stable(bo_wr_side))
    else $error("zero-length packet kept under DMA");
  tr_flag_a: assert property (
    in_token && !bi_rd_avail |=> in_nak ##1 tr_reg)
    else $error("NAK or transfer request flag missing");

  bo_drain_c: cover property (dma_bo && bo_rd_en && bo_rd_last ##1 dma_req_out);
  bi_fill_c: cover property (dma_bi && bi_commit && bi_wr ##1 !bi_wr_free);
  tr_seq_c: cover property (in_nak ##1 tr_reg && in_token);
endmodule

// [rtl/ufedc_pkg.sv]
// Register map, field positions, reset values and sizes for the endpoint buffer control block.
package ufedc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BUF_DEPTH = 64;
  localparam int unsigned SETUP_LEN = 8;

  localparam logic [7:0] OFF_TRIGGER = 8'h00;
  localparam logic [7:0] OFF_DMA = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_WAKE_IRQ_LINE = 8'h0C;
  localparam logic [7:0] OFF_IRQ2 = 8'h10;
  localparam logic [7:0] OFF_SETUP = 8'h14;
  localparam logic [7:0] OFF_BO_DATA = 8'h18;
  localparam logic [7:0] OFF_BI_DATA = 8'h1C;
  localparam logic [7:0] OFF_BO_SIZE = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;

  localparam int unsigned TRG_RD_DONE = 0;
  localparam int unsigned TRG_PKT_EN = 1;
  localparam int unsigned TRG_CLR_BO = 2;
  localparam int unsigned TRG_CLR_BI = 3;

  localparam int unsigned DMA_BO_EN = 0;
  localparam int unsigned DMA_BI_EN = 1;
  localparam int unsigned CTRL_SUSP_ROUTE = 0;
  localparam int unsigned WAKE_IRQ_LINE_TR = 0;

  localparam int unsigned IRQ2_SUSP = 0;
  localparam int unsigned IRQ2_RESUME = 1;
  localparam int unsigned IRQ2_SET_CONFIG_FLAG = 2;
  localparam int unsigned IRQ2_CONFIG_VALID_FLAG = 3;
  localparam int unsigned IRQ2_BUSRST = 4;
  localparam int unsigned IRQ2_POWERED = 5;

  localparam int unsigned ST_BO_AVAIL = 0;
  localparam int unsigned ST_BI_FREE = 1;
  localparam int unsigned ST_SETUP_BUSY = 2;

  localparam logic [1:0] DMA_RST = 2'h0;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [31:0] PRDATA_RST = 32'h0;
  localparam logic [2:0] SETUP_LAST = 3'h7;
endpackage

// [rtl/ufedc_dbuf.sv]
// Two-sided packet buffer with independent write and read side pointers.
`timescale 1ns/100ps
module ufedc_dbuf #(
  parameter int unsigned DW = 8,
  parameter int unsigned DEPTH = 64,
  localparam int unsigned CW = $clog2(DEPTH + 1),
  localparam int unsigned IW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_commit,
  input wire logic rd_en,
  input wire logic rd_done,
  output logic [DW-1:0] rd_data,
  output logic [CW-1:0] rd_len,
  output logic [CW-1:0] wr_cnt,
  output logic rd_avail,
  output logic rd_last,
  output logic wr_free,
  output logic rd_side,
  output logic wr_side
);
  logic [DW-1:0] mem_reg [2][DEPTH];
  logic [DW-1:0] mem_next [2][DEPTH];
  logic [CW-1:0] len_reg [2];
  logic [CW-1:0] len_next [2];
  logic [1:0] full_reg, full_next;
  logic wside_reg, wside_next, rside_reg, rside_next;
  logic [CW-1:0] wcnt_reg, wcnt_next, ridx_reg, ridx_next;

  assign rd_avail = full_reg[rside_reg];
  assign wr_free = !full_reg[wside_reg];
  assign rd_len = rd_avail ? len_reg[rside_reg] : '0;
  assign rd_last = rd_avail && (ridx_reg + 1'b1 == len_reg[rside_reg]);
  assign rd_data = mem_reg[rside_reg][ridx_reg[IW-1:0]];
  assign wr_cnt = wcnt_reg;
  assign rd_side = rside_reg;
  assign wr_side = wside_reg;

  always_comb begin
    mem_next = mem_reg;
    len_next = len_reg;
    full_next = full_reg;
    wside_next = wside_reg;
    rside_next = rside_reg;
    wcnt_next = wcnt_reg;
    ridx_next = ridx_reg;
    if (clear) begin
      full_next = '0;
      wside_next = 1'b0;
      rside_next = 1'b0;
      wcnt_next = '0;
      ridx_next = '0;
    end else begin
      if (wr_en && wr_free && wcnt_reg < CW'(DEPTH)) begin
        mem_next[wside_reg][wcnt_reg[IW-1:0]] = wr_data;
        wcnt_next = wcnt_reg + 1'b1;
      end
      // The commit sees this cycle's byte, so a commit on the last byte counts it.
      if (wr_commit && wr_free) begin
        full_next[wside_reg] = 1'b1;
        len_next[wside_reg] = wcnt_next;
        wside_next = !wside_reg;
        wcnt_next = '0;
      end
      if (rd_en && rd_avail && !rd_last) begin
        ridx_next = ridx_reg + 1'b1;
      end
      if (rd_done && rd_avail) begin
        full_next[rside_reg] = 1'b0;
        rside_next = !rside_reg;
        ridx_next = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg <= '{default: '{default: '0}};
      len_reg <= '{default: '0};
      full_reg <= '0;
      wside_reg <= 1'b0;
      rside_reg <= 1'b0;
      wcnt_reg <= '0;
      ridx_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      len_reg <= len_next;
      full_reg <= full_next;
      wside_reg <= wside_next;
      rside_reg <= rside_next;
      wcnt_reg <= wcnt_next;
      ridx_reg <= ridx_next;
    end
  end
endmodule

// [tb/ufedc_host_model.sv]
// Behavioural USB engine that stands on the far side of the endpoint buffers.
`timescale 1ns/100ps
module ufedc_host_model (
  input wire logic clk,
  output logic rx_wr,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic tx_rd,
  output logic tx_ack,
  output logic in_token,
  output logic setup_start,
  output logic setup_wr,
  output logic [7:0] setup_data
);
  initial begin
    {rx_wr, rx_end, tx_rd, tx_ack, in_token, setup_start, setup_wr} = 7'h00;
    rx_data = 8'h5A;
    setup_data = 8'hA5;
  end
  // Released data lines carry the inverse of the last byte, so a stale byte never looks valid.
  task automatic send(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_wr <= 1'b1;
      rx_data <= base + 8'(i);
    end
    @(posedge clk);
    rx_wr <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask
  task automatic take(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_rd <= 1'b1;
    end
    @(posedge clk);
    tx_rd <= 1'b0;
    tx_ack <= 1'b1;
    @(posedge clk);
    tx_ack <= 1'b0;
  endtask
  task automatic token();
    @(posedge clk);
    in_token <= 1'b1;
    @(posedge clk);
    in_token <= 1'b0;
  endtask
  task automatic setup(input logic [7:0] base);
    @(posedge clk);
    setup_start <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      setup_start <= 1'b0;
      setup_wr <= 1'b1;
      setup_data <= base + 8'(i);
    end
    @(posedge clk);
    setup_wr <= 1'b0;
    setup_data <= ~setup_data;
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the endpoint buffer control block.
`timescale 1ns/100ps
module tb;
  import ufedc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, config_value = 8'h00, tx_data, rx_data, setup_data;
  logic [31:0] pwdata = 32'h0, prdata;
  logic vbus_pin = 1'b0, dp_pin = 1'b1, dm_pin = 1'b0;
  logic suspend_evt = 1'b0, resume_evt = 1'b0, set_config_evt = 1'b0;
  logic pready, pslverr, rx_ready, tx_ready, in_nak, dma_req_out, dma_req_in, usb_powered, bus_reset;
  logic suspend_irq_line, wake_irq_line, rx_wr, rx_end, tx_rd, tx_ack, in_token, setup_start, setup_wr;
  logic [2:0] tx_len;
  int err_count = 0, n_tests = 0, cyc = 0;
  logic [31:0] rd;
  logic se;
  always #5 clk = ~clk;
  ufedc_top #(.DEPTH(4)) u_ufedc_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbus_pin(vbus_pin), .dp_pin(dp_pin), .dm_pin(dm_pin), .rx_wr(rx_wr), .rx_data(rx_data), .rx_end(rx_end),
    .rx_ready(rx_ready), .tx_rd(tx_rd), .tx_ack(tx_ack), .tx_data(tx_data), .tx_len(tx_len),
    .tx_ready(tx_ready), .in_token(in_token), .in_nak(in_nak), .setup_start(setup_start),
    .setup_wr(setup_wr), .setup_data(setup_data), .suspend_evt(suspend_evt), .resume_evt(resume_evt),
    .set_config_evt(set_config_evt), .config_value(config_value), .dma_req_out(dma_req_out),
    .dma_req_in(dma_req_in), .usb_powered(usb_powered), .bus_reset(bus_reset),
    .suspend_irq_line(suspend_irq_line), .wake_irq_line(wake_irq_line));
  ufedc_host_model u_ufedc_host_model (.clk(clk), .rx_wr(rx_wr), .rx_data(rx_data), .rx_end(rx_end),
    .tx_rd(tx_rd), .tx_ack(tx_ack), .in_token(in_token), .setup_start(setup_start), .setup_wr(setup_wr),
    .setup_data(setup_data));
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // The wait ends when pready is high; if it never rises, only the bench timeout ends it.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk("reset levels", 32'h10, {dma_req_out, dma_req_in, rx_ready, tx_ready, tx_len});
    rdc("dma reg", OFF_DMA, 32'h0);
    rdc("ctrl reg", OFF_CTRL, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    chk("slverr", 32'h1, se);
  endtask
  task automatic t_token();
    u_ufedc_host_model.token();
    #1;
    chk("in_nak", 32'h1, in_nak);
    rdc("tr flag", OFF_WAKE_IRQ_LINE, 32'h1);
    apb(1'b1, OFF_WAKE_IRQ_LINE, 32'h1);
    rdc("tr cleared", OFF_WAKE_IRQ_LINE, 32'h0);
    u_ufedc_host_model.token();
    st(3);
    rdc("tr again", OFF_WAKE_IRQ_LINE, 32'h1);
  endtask
  task automatic t_setup();
    fork
      u_ufedc_host_model.setup(8'h30);
      begin
        st(3);
        rdc("setup busy read", OFF_SETUP, 32'h0);
      end
    join
    st(2);
    for (int i = 0; i < 8; i++) rdc("setup byte", OFF_SETUP, 32'h30 + i);
  endtask
  task automatic t_config();
    @(posedge clk);
    config_value <= 8'h01;
    set_config_evt <= 1'b1;
    @(posedge clk);
    set_config_evt <= 1'b0;
    st(2);
    apb(1'b0, OFF_IRQ2, 32'h0);
    chk("set_config_flag config_valid_flag", 32'h3, (rd >> 2) & 32'h3);
  endtask
  task automatic t_suspend();
    apb(1'b1, OFF_CTRL, 32'h0);
    @(posedge clk);
    suspend_evt <= 1'b1;
    @(posedge clk);
    suspend_evt <= 1'b0;
    st(3);
    chk("irq unrouted", 32'h0, suspend_irq_line);
    apb(1'b1, OFF_CTRL, 32'h1);
    @(posedge clk);
    resume_evt <= 1'b1;
    @(posedge clk);
    resume_evt <= 1'b0;
    st(3);
    chk("irq routed", 32'h3, {suspend_irq_line, wake_irq_line});
  endtask
  task automatic pins(input logic v, input logic p, input logic m);
    @(posedge clk);
    vbus_pin <= v;
    dp_pin <= p;
    dm_pin <= m;
    st(5);
  endtask
  task automatic t_power();
    pins(1'b0, 1'b0, 1'b0);
    chk("no vbus", 32'h0, {usb_powered, bus_reset});
    pins(1'b1, 1'b1, 1'b0);
    chk("powered", 32'h1, usb_powered);
    u_ufedc_host_model.send(1, 8'hC0);
    st(2);
    rdc("stale data", OFF_STATUS, 32'h3);
    apb(1'b1, OFF_TRIGGER, 32'hC);
    rdc("cleared", OFF_STATUS, 32'h2);
    pins(1'b1, 1'b0, 1'b0);
    chk("se0 reset", 32'h1, bus_reset);
    pins(1'b1, 1'b1, 1'b0);
    apb(1'b1, OFF_IRQ2, 32'h10);
    pins(1'b0, 1'b0, 1'b0);
    chk("held state", 32'h2, {usb_powered, bus_reset});
  endtask
  task automatic t_bulk_out();
    apb(1'b1, OFF_DMA, 32'h1);
    u_ufedc_host_model.send(0, 8'h00);
    st(2);
    chk("zero length", 32'h0, dma_req_out);
    u_ufedc_host_model.send(2, 8'hA0);
    st(2);
    chk("out req", 32'h1, dma_req_out);
    rdc("out size", OFF_BO_SIZE, 32'h2);
    apb(1'b1, OFF_TRIGGER, 32'h4);
    st(2);
    chk("clear ignored", 32'h1, dma_req_out);
    for (int i = 0; i < 2; i++) rdc("out byte", OFF_BO_DATA, 32'hA0 + i);
    st(2);
    chk("auto switch", 32'h0, dma_req_out);
    u_ufedc_host_model.send(3, 8'hB0);
    st(2);
    rdc("next size", OFF_BO_SIZE, 32'h3);
    for (int i = 0; i < 3; i++) rdc("out byte", OFF_BO_DATA, 32'hB0 + i);
    apb(1'b1, OFF_DMA, 32'h0);
  endtask
  task automatic t_bulk_in();
    apb(1'b1, OFF_DMA, 32'h2);
    st(2);
    chk("in req", 32'h1, dma_req_in);
    for (int i = 0; i < 4; i++) apb(1'b1, OFF_BI_DATA, 32'h10 + i);
    st(2);
    chk("auto commit", 32'hC, {tx_ready, tx_len});
    chk("req stays", 32'h1, dma_req_in);
    chk("tx byte", 32'h10, tx_data);
    for (int i = 0; i < 2; i++) apb(1'b1, OFF_BI_DATA, 32'h20 + i);
    st(2);
    chk("short kept", 32'hC, {dma_req_in, tx_len});
    apb(1'b1, OFF_TRIGGER, 32'h2);
    st(2);
    chk("both full", 32'h0, dma_req_in);
    u_ufedc_host_model.take(4);
    st(2);
    chk("next side", 32'hA, {dma_req_in, tx_len});
    u_ufedc_host_model.take(2);
    st(2);
    chk("drained", 32'h0, tx_len);
    apb(1'b1, OFF_DMA, 32'h0);
    st(2);
    chk("req withdrawn", 32'h0, dma_req_in);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    st(1);
    t_reset();
    t_token();
    t_setup();
    t_config();
    t_suspend();
    t_bulk_out();
    t_bulk_in();
    t_power();
    summarize();
  end
endmodule
